// *** pkg/strap_cfg_pkg.sv ***
// Constants, types and state records for the strap configuration and mode select block.
// Assumes one 200 MHz core clock and a synchronous active-low reset shared by all files.
//
// Overview of operation
// - Six operating modes plus development overlay.
// - Init mode at power-up and soft reset.
// - Restart asserts reset after wake or failure.
// - Stop keeps regulator on, sleep turns off.
// - Critical failures such as overtemperature enter fail-safe.
// - Development mode: watchdog failure raises interrupt only.
// - Development mode may re-enable watchdog reset.
// - Watchdog always starts with long window.
// - Thirty-two bit serial frames carry all control.
// - Test pin weakly pulled up after reset release.
// - Development latch needs init, supply, flag, reset high.
// - Low test pin plus command latches development.
// - Test pin filter restarts at one on release.
// - Uncommanded mode change out of power-up init cancels development mode.
// - Strap pulled low enables checksum, open disables.
// - Strap capture needs init/restart, supply, flag, reset low.
// - Strap filtered during delay, latched at release.
// - Frame 67aaaa0e enables the checksum.
// - Frame e7aaaac3 disables the checksum.
// - Straps at power-up, checksum also in restart.
// - Init watchdog long window starts at release.
package strap_cfg_pkg;

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Timing.
   localparam int CLK_PERIOD_NS = 5;
   localparam int RESET_DELAY_TIME_NS = 10000;
   localparam int STRAP_FILTER_TIME_NS = 2000;
   localparam int DEVMODE_FILTER_TIME_NS = 2000;
   localparam int RD_CYC = (RESET_DELAY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int STRAP_FILT_CYC = (STRAP_FILTER_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int DEV_FILT_CYC = (DEVMODE_FILTER_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CNT_W = 12;

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Recovery frames and reset values.
   localparam logic [31:0] FRAME_CHK_ON = 32'h67aaaa0e;
   localparam logic [31:0] FRAME_CHK_OFF = 32'he7aaaac3;
   localparam logic FILT_RESET_VAL = 1'h1;
   localparam logic CHK_RESET_VAL = 1'h0;

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Operating modes.
   typedef enum logic [2:0] {
      MODE_INIT = 3'h0,
      MODE_NORMAL = 3'h1,
      MODE_STOP = 3'h2,
      MODE_SLEEP = 3'h3,
      MODE_RESTART = 3'h4,
      MODE_FAILSAFE = 3'h5
   } mode_e;

   // State of one pin filter.
   typedef struct packed {
      logic [2:0] sync;
      logic [CNT_W-1:0] cnt;
      logic out;
   } filt_s;

   // State of the recovery frame matcher.
   typedef struct packed {
      logic on;
      logic off;
   } match_s;

   // Serial command strobes seen by the block.
   typedef struct packed {
      logic any_cmd;
      logic mode_req;
      mode_e mode_sel;
      logic soft_rst;
      logic wd_reen;
   } spi_cmd_s;

   // Failure and wake events.
   typedef struct packed {
      logic thermal_sd;
      logic wd_fail;
      logic vcc_uv;
      logic wake;
   } event_s;

   // State of the main block.
   typedef struct packed {
      mode_e mode;
      logic rst_low;
      logic [CNT_W-1:0] rd_cnt;
      logic pwrup;
      logic devmode;
      logic wd_rst_en;
      logic chk_en;
      logic intn_pu;
      logic wd_long;
      logic wd_irq;
      logic reg_en;
   } core_s;

endpackage : strap_cfg_pkg

// *** core/pin_filter.sv ***
// Pin synchroniser and debounce filter.
// Assumes an asynchronous pin; load forces the output to its start value.
`timescale 1ns/1ps
module pin_filter #(
   parameter int CYC = 400
) (
   // Clock and reset.
   input wire logic core_clk_i,
   input wire logic reset_output_low_i,
   // Pin and control.
   input wire logic pin_i,
   input wire logic load_i,
   // Filtered level.
   output logic filt_o
);

   strap_cfg_pkg::filt_s s;
   strap_cfg_pkg::filt_s n;

   // Three stages; only the last two are compared, the first feeds the second alone.
   always_comb begin
      n = s;
      n.sync = {s.sync[1:0], pin_i};
      if (load_i) begin
         n.out = strap_cfg_pkg::FILT_RESET_VAL;
         n.cnt = '0;
      end else if (s.sync[2] == s.sync[1] && s.sync[2] != s.out) begin
         n.cnt = s.cnt + 1'b1;
         if (s.cnt == strap_cfg_pkg::CNT_W'(CYC - 1)) begin
            n.out = s.sync[2];
            n.cnt = '0;
         end
      end else begin
         n.cnt = '0;
      end
   end

   // State register.
   always_ff @(posedge core_clk_i) begin
      if (!reset_output_low_i) begin
         s <= '{sync: 3'h7, cnt: '0, out: strap_cfg_pkg::FILT_RESET_VAL};
      end else begin
         s <= n;
      end
   end

   assign filt_o = s.out;

endmodule : pin_filter

// *** core/frame_match.sv ***
// Exact match of the two checksum recovery frames.
// Assumes frame_valid_i is a one-cycle strobe with a whole 32-bit frame.
`timescale 1ns/1ps
module frame_match (
   // Clock and reset.
   input wire logic core_clk_i,
   input wire logic reset_output_low_i,
   // Received frame.
   input wire logic frame_valid_i,
   input wire logic [31:0] frame_i,
   // Match pulses.
   output logic on_o,
   output logic off_o
);

   strap_cfg_pkg::match_s s;
   strap_cfg_pkg::match_s n;

   // Whole-word compare, independent of the checksum setting in force.
   always_comb begin
      n.on = frame_valid_i && (frame_i == strap_cfg_pkg::FRAME_CHK_ON);
      n.off = frame_valid_i && (frame_i == strap_cfg_pkg::FRAME_CHK_OFF);
   end

   // State register.
   always_ff @(posedge core_clk_i) begin
      if (!reset_output_low_i) begin
         s <= '0;
      end else begin
         s <= n;
      end
   end

   assign on_o = s.on;
   assign off_o = s.off;

endmodule : frame_match

// *** core/strap_config_and_mode_select.sv ***
// Operating mode sequencer with hardware strap capture and checksum recovery.
// Assumes serial frames are decoded elsewhere and arrive as one-cycle strobes;
// pins are asynchronous and are filtered here.
`timescale 1ns/1ps
module strap_config_and_mode_select (
   // Clock and reset.
   input wire logic core_clk_i,
   input wire logic reset_output_low_i,
   // Pins.
   input wire logic intn_test_i,
   input wire logic pwm_in1_checksum_strap_i,
   // Supply status.
   input wire logic por_flag_i,
   input wire logic vcc_above_rt_i,
   // Events and serial commands.
   input wire strap_cfg_pkg::event_s evt_i,
   input wire strap_cfg_pkg::spi_cmd_s cmd_i,
   input wire logic frame_valid_i,
   input wire logic [31:0] frame_i,
   // Mode and reset.
   output strap_cfg_pkg::mode_e mode_o,
   output logic reset_output_low_o,
   output logic main_regulator_en_o,
   // Configuration and watchdog.
   output logic devmode_o,
   output logic checksum_en_o,
   output logic intn_pullup_en_o,
   output logic wd_long_start_o,
   output logic wd_fail_irq_o
);

   strap_cfg_pkg::core_s s;
   strap_cfg_pkg::core_s n;
   logic intn_filt;
   logic chk_filt;
   logic rel;
   logic mon;
   logic cap_ok;
   logic frm_on;
   logic frm_off;

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Pin filters and frame matcher.

   // Test pin filter restarts at one when the reset output is released.
   pin_filter #(.CYC(strap_cfg_pkg::DEV_FILT_CYC)) u_intn_filt (
      .core_clk_i(core_clk_i),
      .reset_output_low_i(reset_output_low_i),
      .pin_i(intn_test_i),
      .load_i(rel),
      .filt_o(intn_filt)
   );

   // Strap filter runs continuously; restarted on entry to restart mode.
   pin_filter #(.CYC(strap_cfg_pkg::STRAP_FILT_CYC)) u_chk_filt (
      .core_clk_i(core_clk_i),
      .reset_output_low_i(reset_output_low_i),
      .pin_i(pwm_in1_checksum_strap_i),
      .load_i(n.mode == strap_cfg_pkg::MODE_RESTART && s.mode != strap_cfg_pkg::MODE_RESTART),
      .filt_o(chk_filt)
   );

   // Frames are a full 32-bit word from the serial slave.
   frame_match u_frame_match (
      .core_clk_i(core_clk_i),
      .reset_output_low_i(reset_output_low_i),
      .frame_valid_i(frame_valid_i),
      .frame_i(frame_i),
      .on_o(frm_on),
      .off_o(frm_off)
   );

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Qualifiers.

   // Reset output is released at the last cycle of the delay.
   assign rel = s.rst_low && (s.mode == strap_cfg_pkg::MODE_INIT ||
                s.mode == strap_cfg_pkg::MODE_RESTART) &&
                (s.rd_cnt == strap_cfg_pkg::CNT_W'(strap_cfg_pkg::RD_CYC - 1));

   // Window in which the test pin is watched for development mode.
   assign mon = (s.mode == strap_cfg_pkg::MODE_INIT) && s.pwrup && vcc_above_rt_i &&
                por_flag_i && !s.rst_low;

   // Window in which the checksum strap may be captured.
   assign cap_ok = ((s.mode == strap_cfg_pkg::MODE_INIT && s.pwrup) ||
                   s.mode == strap_cfg_pkg::MODE_RESTART) &&
                   vcc_above_rt_i && por_flag_i && s.rst_low;

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Next-state logic.
   always_comb begin
      n = s;
      n.wd_long = 1'b0;
      n.wd_irq = 1'b0;
      // Reset delay count while the reset output is held in init or restart.
      if (s.rst_low && (s.mode == strap_cfg_pkg::MODE_INIT ||
          s.mode == strap_cfg_pkg::MODE_RESTART)) begin
         n.rd_cnt = s.rd_cnt + 1'b1;
      end
      if (rel) begin
         n.rst_low = 1'b0;
         n.rd_cnt = '0;
         n.wd_long = 1'b1;
      end
      // Mode changes by wake, request and restart completion.
      case (s.mode)
         strap_cfg_pkg::MODE_INIT, strap_cfg_pkg::MODE_NORMAL, strap_cfg_pkg::MODE_STOP: begin
            if (cmd_i.mode_req && !s.rst_low &&
                (cmd_i.mode_sel == strap_cfg_pkg::MODE_NORMAL ||
                 cmd_i.mode_sel == strap_cfg_pkg::MODE_STOP ||
                 cmd_i.mode_sel == strap_cfg_pkg::MODE_SLEEP)) begin
               n.mode = cmd_i.mode_sel;
            end
         end
         strap_cfg_pkg::MODE_SLEEP, strap_cfg_pkg::MODE_FAILSAFE: begin
            if (evt_i.wake) begin
               n.mode = strap_cfg_pkg::MODE_RESTART;
               n.rst_low = 1'b1;
               n.rd_cnt = '0;
            end
         end
         strap_cfg_pkg::MODE_RESTART: begin
            if (rel) begin
               n.mode = strap_cfg_pkg::MODE_NORMAL;
            end
         end
         default: begin
            n.mode = strap_cfg_pkg::MODE_INIT;
         end
      endcase
      // Soft reset returns to init but not as a power-up.
      if (cmd_i.soft_rst) begin
         n.mode = strap_cfg_pkg::MODE_INIT;
         n.pwrup = 1'b0;
      end
      // Watchdog failure: interrupt only in development mode unless re-enabled.
      if (evt_i.wd_fail && s.mode != strap_cfg_pkg::MODE_SLEEP &&
          s.mode != strap_cfg_pkg::MODE_FAILSAFE) begin
         if (s.devmode && !s.wd_rst_en) begin
            n.wd_irq = 1'b1;
         end else begin
            n.mode = strap_cfg_pkg::MODE_RESTART;
            n.rst_low = 1'b1;
            n.rd_cnt = '0;
         end
      end
      // Supply undervoltage forces a restart outside sleep and fail-safe modes.
      if (evt_i.vcc_uv && s.mode != strap_cfg_pkg::MODE_SLEEP &&
          s.mode != strap_cfg_pkg::MODE_FAILSAFE) begin
         n.mode = strap_cfg_pkg::MODE_RESTART;
         n.rst_low = 1'b1;
         n.rd_cnt = '0;
      end
      // Critical failure wins over everything else and holds the reset output.
      if (evt_i.thermal_sd) begin
         n.mode = strap_cfg_pkg::MODE_FAILSAFE;
         n.rst_low = 1'b1;
         n.rd_cnt = '0;
      end
      // Leaving init ends the power-up episode.
      if (n.mode != strap_cfg_pkg::MODE_INIT) begin
         n.pwrup = 1'b0;
      end
      // Development mode latch on a low filtered test pin and any command.
      if (mon && cmd_i.any_cmd && !intn_filt) begin
         n.devmode = 1'b1;
      end
      if (mon && n.mode != s.mode && !cmd_i.mode_req && !cmd_i.soft_rst) begin
         n.devmode = 1'b0;
      end
      // Watchdog reset re-enable is only meaningful in development mode.
      if (!s.devmode) begin
         n.wd_rst_en = 1'b0;
      end else if (cmd_i.wd_reen) begin
         n.wd_rst_en = 1'b1;
      end
      // Strap latched at the release edge of the reset output; low pin enables.
      if (cap_ok && rel) begin
         n.chk_en = !chk_filt;
      end
      // Recovery frames override the setting; the host keeps them to normal mode.
      if (frm_on) begin
         n.chk_en = 1'b1;
      end else if (frm_off) begin
         n.chk_en = 1'b0;
      end
      n.intn_pu = !n.rst_low;
      n.reg_en = (n.mode != strap_cfg_pkg::MODE_SLEEP);
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   // State register.
   always_ff @(posedge core_clk_i) begin
      if (!reset_output_low_i) begin
         s <= '{mode: strap_cfg_pkg::MODE_INIT, rst_low: 1'b1, rd_cnt: '0, pwrup: 1'b1,
                devmode: 1'b0, wd_rst_en: 1'b0, chk_en: strap_cfg_pkg::CHK_RESET_VAL,
                intn_pu: 1'b0, wd_long: 1'b0, wd_irq: 1'b0, reg_en: 1'b1};
      end else begin
         s <= n;
      end
   end

   // Outputs straight from the state register.
   assign mode_o = s.mode;
   assign reset_output_low_o = s.rst_low;
   assign main_regulator_en_o = s.reg_en;
   assign devmode_o = s.devmode;
   assign checksum_en_o = s.chk_en;
   assign intn_pullup_en_o = s.intn_pu;
   assign wd_long_start_o = s.wd_long;
   assign wd_fail_irq_o = s.wd_irq;

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Assertions.
   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (!reset_output_low_i);

   AST_SIX_MODES: assert property (
      s.mode inside {strap_cfg_pkg::MODE_INIT, strap_cfg_pkg::MODE_NORMAL,
                     strap_cfg_pkg::MODE_STOP, strap_cfg_pkg::MODE_SLEEP,
                     strap_cfg_pkg::MODE_RESTART, strap_cfg_pkg::MODE_FAILSAFE})
      else $error("Mode outside the six operating modes.");

   AST_SOFT_INIT: assert property (
      cmd_i.soft_rst && !evt_i.thermal_sd && !evt_i.vcc_uv && !evt_i.wd_fail
      |=> mode_o == strap_cfg_pkg::MODE_INIT && !n.pwrup)
      else $error("Soft reset did not enter init mode.");

   AST_RESTART_RST: assert property (
      evt_i.vcc_uv && !evt_i.thermal_sd && !cmd_i.soft_rst &&
      mode_o inside {strap_cfg_pkg::MODE_NORMAL, strap_cfg_pkg::MODE_STOP}
      |=> mode_o == strap_cfg_pkg::MODE_RESTART && reset_output_low_o)
      else $error("Undervoltage did not restart with reset asserted.");

   AST_REGULATOR: assert property (
      (mode_o == strap_cfg_pkg::MODE_SLEEP) == !main_regulator_en_o)
      else $error("Regulator state does not follow sleep mode.");

   AST_FAILSAFE: assert property (
      evt_i.thermal_sd |=> mode_o == strap_cfg_pkg::MODE_FAILSAFE && reset_output_low_o)
      else $error("Thermal failure did not enter fail-safe mode.");

   AST_DEV_WD_IRQ: assert property (
      devmode_o && !s.wd_rst_en && evt_i.wd_fail && !evt_i.thermal_sd && !evt_i.vcc_uv &&
      mode_o inside {strap_cfg_pkg::MODE_INIT, strap_cfg_pkg::MODE_NORMAL,
                     strap_cfg_pkg::MODE_STOP}
      |=> wd_fail_irq_o && mode_o != strap_cfg_pkg::MODE_RESTART)
      else $error("Development mode watchdog failure caused a reset.");

   AST_WD_REEN: assert property (
      devmode_o && cmd_i.wd_reen |=> s.wd_rst_en)
      else $error("Watchdog reset re-enable was not taken.");

   AST_LONG_WINDOW: assert property (
      $fell(reset_output_low_o) |-> wd_long_start_o && intn_pullup_en_o)
      else $error("Reset release did not start the long window.");

   AST_RD_LENGTH: assert property (
      $rose(reset_output_low_o) && mode_o == strap_cfg_pkg::MODE_RESTART &&
      !evt_i.thermal_sd && !evt_i.vcc_uv && !evt_i.wd_fail && !cmd_i.soft_rst
      ##1 (!evt_i.thermal_sd && !evt_i.vcc_uv && !evt_i.wd_fail && !cmd_i.soft_rst)[*8]
      |-> reset_output_low_o)
      else $error("Reset output released too early.");

   AST_DEV_GATE: assert property (
      $rose(devmode_o) |-> $past(mon) && !$past(intn_filt))
      else $error("Development mode latched outside its window.");

   AST_STRAP_LATCH: assert property (
      cap_ok && rel && !frm_on && !frm_off |=> checksum_en_o == !$past(chk_filt))
      else $error("Checksum strap not latched at release.");

   AST_FRAME_ON: assert property (
      frame_valid_i && frame_i == strap_cfg_pkg::FRAME_CHK_ON ##1 !(cap_ok && rel)
      |=> checksum_en_o)
      else $error("Enable frame did not set the checksum.");

   AST_FRAME_OFF: assert property (
      frame_valid_i && frame_i == strap_cfg_pkg::FRAME_CHK_OFF ##1 !(cap_ok && rel)
      |=> !checksum_en_o)
      else $error("Disable frame did not clear the checksum.");

   COV_DEVMODE: cover property ($rose(devmode_o));
   COV_RESTART: cover property (mode_o == strap_cfg_pkg::MODE_RESTART ##1
                                mode_o == strap_cfg_pkg::MODE_NORMAL);
   COV_FRAME_ON: cover property (frm_on && !checksum_en_o);
   COV_SLEEP: cover property (mode_o == strap_cfg_pkg::MODE_SLEEP);

endmodule : strap_config_and_mode_select

// *** testbench/host_strap_model.sv ***
// Host and strap resistor model for the strap configuration block.
// Assumes the bench drives its requests just after a rising clock edge.
`timescale 1ns/1ps
module host_strap_model (
   // Clock.
   input wire logic core_clk_i,
   // Resistors fitted and device pull-up.
   input wire logic test_pulldown_i,
   input wire logic strap_pulldown_i,
   input wire logic pullup_en_i,
   // Frame requests and device mode.
   input wire logic send_i,
   input wire logic [31:0] req_frame_i,
   input wire strap_cfg_pkg::mode_e mode_i,
   // Pins and frame strobe.
   output logic test_pin_o,
   output logic strap_pin_o,
   output logic frame_valid_o,
   output logic [31:0] frame_o
);
   logic float_lvl = 1'h0;

   ////////////////////////////////////////////////////////////////////////////////
   // An undriven test pin wanders, so it flips every cycle.
   always @(posedge core_clk_i) begin
      float_lvl <= ~float_lvl;
   end

   // A fitted pull-down wins over the weak internal pull-up.
   assign test_pin_o = test_pulldown_i ? 1'h0 : (pullup_en_i ? 1'h1 : float_lvl);
   // An open strap sits high on its internal pull; a pull-down asks for checksum.
   assign strap_pin_o = strap_pulldown_i ? 1'h0 : 1'h1;

   // Recovery frames go out only in normal mode; the idle bus carries junk.
   initial frame_valid_o = 1'h0;
   initial frame_o = 32'h0;
   always @(posedge core_clk_i) begin
      frame_valid_o <= send_i && (mode_i == strap_cfg_pkg::MODE_NORMAL);
      frame_o <= send_i ? req_frame_i : ~frame_o;
   end
endmodule : host_strap_model

// *** testbench/strap_config_and_mode_select_tb.sv ***
// Self-checking bench for the strap configuration and mode select block.
// Assumes the host model drives pins and frames; the bench drives the rest.
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin error_cnt++; \
   $display("mismatch %s expected %0h seen %0h", nm, ex, got); end end
module strap_config_and_mode_select_tb;
   logic core_clk_i = 1'h0;
   logic reset_output_low_i = 1'h0;
   logic por_flag_i = 1'h1;
   logic vcc_above_rt_i = 1'h1;
   logic test_pd = 1'h1;
   logic strap_pd = 1'h1;
   logic send = 1'h0;
   logic [31:0] req_frame = 32'h0;
   strap_cfg_pkg::event_s evt_i = '0;
   strap_cfg_pkg::spi_cmd_s cmd_i = '0;
   logic test_pin;
   logic strap_pin;
   logic frame_valid;
   logic [31:0] frame;
   strap_cfg_pkg::mode_e mode_o;
   logic reset_output_low_o;
   logic main_regulator_en_o;
   logic devmode_o;
   logic checksum_en_o;
   logic intn_pullup_en_o;
   logic wd_long_start_o;
   logic wd_fail_irq_o;
   int error_cnt = 0;
   int checked = 0;
   int cycles = 0;
   logic [31:0] frames [5] = '{32'h67aaaa0e, 32'h67aaaa0e, 32'h67aaaa0f, 32'he7aaaac3,
                               32'he7aaaac2};
   logic chk_exp [5] = '{1'h1, 1'h1, 1'h1, 1'h0, 1'h0};

   ////////////////////////////////////////////////////////////////////////////////
   // Device and far side.
   strap_config_and_mode_select strap_config_and_mode_select_inst (
      .core_clk_i(core_clk_i), .reset_output_low_i(reset_output_low_i), .intn_test_i(test_pin),
      .pwm_in1_checksum_strap_i(strap_pin), .por_flag_i(por_flag_i),
      .vcc_above_rt_i(vcc_above_rt_i), .evt_i(evt_i), .cmd_i(cmd_i),
      .frame_valid_i(frame_valid), .frame_i(frame), .mode_o(mode_o),
      .reset_output_low_o(reset_output_low_o), .main_regulator_en_o(main_regulator_en_o),
      .devmode_o(devmode_o), .checksum_en_o(checksum_en_o),
      .intn_pullup_en_o(intn_pullup_en_o), .wd_long_start_o(wd_long_start_o),
      .wd_fail_irq_o(wd_fail_irq_o));
   host_strap_model host_strap_model_inst (
      .core_clk_i(core_clk_i), .test_pulldown_i(test_pd), .strap_pulldown_i(strap_pd),
      .pullup_en_i(intn_pullup_en_o), .send_i(send), .req_frame_i(req_frame),
      .mode_i(mode_o), .test_pin_o(test_pin), .strap_pin_o(strap_pin),
      .frame_valid_o(frame_valid), .frame_o(frame));

   ////////////////////////////////////////////////////////////////////////////////
   // Clock and hang guard.
   initial begin
      forever #2.5 core_clk_i = ~core_clk_i;
   end
   always @(posedge core_clk_i) begin
      cycles++;
      if (cycles == 40000) begin
         error_cnt++;
         $display("timeout after %0d cycles", cycles);
         conclude();
      end
   end

   // Prints the counts and the verdict, then stops the run.
   task automatic conclude();
      $display("checks %0d mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : conclude

   // Waits n edges; every task starts and ends just after an edge.
   task automatic tick(input int n);
      repeat (n) @(posedge core_clk_i);
      #1;
   endtask : tick

   // One-cycle event strobe: thermal, watchdog, undervoltage, wake from msb down.
   task automatic evt(input logic [3:0] e);
      evt_i = strap_cfg_pkg::event_s'(e);
      tick(1);
      evt_i = '0;
   endtask : evt

   // One-cycle serial command strobe.
   task automatic cmd(input logic any, input logic req, input strap_cfg_pkg::mode_e sel,
                      input logic srst, input logic reen);
      cmd_i = '{any, req, sel, srst, reen};
      tick(1);
      cmd_i = '0;
   endtask : cmd

   // Sends one frame through the host and checks the setting three edges after it lands.
   task automatic send_frame(input logic [31:0] f, input logic ex);
      req_frame = f;
      send = 1'h1;
      tick(1);
      send = 1'h0;
      tick(3);
      `CHK("checksum after frame", ex, checksum_en_o)
   endtask : send_frame

   // Waits for the reset output to release and checks what comes with it.
   task automatic wait_release();
      int n;
      n = 0;
      while (reset_output_low_o !== 1'h0 && n < strap_cfg_pkg::RD_CYC + 8) begin
         tick(1);
         n++;
      end
      `CHK("reset delay", strap_cfg_pkg::RD_CYC, n)
      `CHK("long window start", 1'h1, wd_long_start_o)
      `CHK("pull-up on", 1'h1, intn_pullup_en_o)
   endtask : wait_release

   // Power-on reset with the given flag and resistors, then the strap outcome.
   task automatic power_up(input logic por, input logic tpd, input logic spd, input logic ex);
      reset_output_low_i = 1'h0;
      por_flag_i = por;
      test_pd = tpd;
      strap_pd = spd;
      tick(2);
      reset_output_low_i = 1'h1;
      `CHK("mode at power-up", strap_cfg_pkg::MODE_INIT, mode_o)
      `CHK("pull-up off", 1'h0, intn_pullup_en_o)
      `CHK("reset output", 1'h1, reset_output_low_o)
      wait_release();
      `CHK("strap checksum", ex, checksum_en_o)
   endtask : power_up

   ////////////////////////////////////////////////////////////////////////////////
   // Test sequence.
   initial begin
      // Development mode latch and watchdog handling.
      power_up(1'h1, 1'h1, 1'h1, 1'h1);
      cmd(1'h1, 1'h0, strap_cfg_pkg::MODE_INIT, 1'h0, 1'h0);
      `CHK("devmode before filter", 1'h0, devmode_o)
      tick(420);
      cmd(1'h1, 1'h0, strap_cfg_pkg::MODE_INIT, 1'h0, 1'h0);
      `CHK("devmode latched", 1'h1, devmode_o)
      evt(4'h4);
      `CHK("watchdog irq", 1'h1, wd_fail_irq_o)
      `CHK("no restart", strap_cfg_pkg::MODE_INIT, mode_o)
      cmd(1'h0, 1'h0, strap_cfg_pkg::MODE_INIT, 1'h0, 1'h1);
      `CHK("watchdog irq pulse", 1'h0, wd_fail_irq_o)
      evt(4'h4);
      `CHK("reset re-enabled", strap_cfg_pkg::MODE_RESTART, mode_o)
      wait_release();
      `CHK("devmode dropped", 1'h0, devmode_o)
      `CHK("restart exit", strap_cfg_pkg::MODE_NORMAL, mode_o)
      $display("test devmode done");
      // Power saving levels and strap capture in restart.
      cmd(1'h1, 1'h1, strap_cfg_pkg::MODE_STOP, 1'h0, 1'h0);
      `CHK("stop mode", strap_cfg_pkg::MODE_STOP, mode_o)
      `CHK("regulator in stop", 1'h1, main_regulator_en_o)
      cmd(1'h1, 1'h1, strap_cfg_pkg::MODE_SLEEP, 1'h0, 1'h0);
      `CHK("sleep mode", strap_cfg_pkg::MODE_SLEEP, mode_o)
      `CHK("regulator in sleep", 1'h0, main_regulator_en_o)
      strap_pd = 1'h0;
      evt(4'h1);
      `CHK("wake restart", strap_cfg_pkg::MODE_RESTART, mode_o)
      `CHK("reset on wake", 1'h1, reset_output_low_o)
      `CHK("regulator on", 1'h1, main_regulator_en_o)
      wait_release();
      `CHK("restart strap", 1'h0, checksum_en_o)
      $display("test power levels done");
      // Recovery frames in normal mode.
      for (int i = 0; i < 5; i++) begin
         send_frame(frames[i], chk_exp[i]);
      end
      $display("test recovery frames done");
      // Fail-safe, undervoltage and soft reset.
      evt(4'h8);
      `CHK("fail-safe", strap_cfg_pkg::MODE_FAILSAFE, mode_o)
      tick(2100);
      `CHK("fail-safe holds reset", 1'h1, reset_output_low_o)
      evt(4'h1);
      `CHK("fail-safe wake", strap_cfg_pkg::MODE_RESTART, mode_o)
      wait_release();
      evt(4'h2);
      `CHK("undervoltage", strap_cfg_pkg::MODE_RESTART, mode_o)
      wait_release();
      cmd(1'h1, 1'h0, strap_cfg_pkg::MODE_INIT, 1'h1, 1'h0);
      `CHK("soft reset", strap_cfg_pkg::MODE_INIT, mode_o)
      `CHK("soft reset output", 1'h0, reset_output_low_o)
      tick(420);
      cmd(1'h1, 1'h0, strap_cfg_pkg::MODE_INIT, 1'h0, 1'h0);
      `CHK("no devmode after soft reset", 1'h0, devmode_o)
      $display("test failures done");
      // Open straps, then a cleared power-on flag.
      power_up(1'h1, 1'h0, 1'h0, 1'h0);
      tick(420);
      cmd(1'h1, 1'h0, strap_cfg_pkg::MODE_INIT, 1'h0, 1'h0);
      `CHK("no devmode with pull-up", 1'h0, devmode_o)
      power_up(1'h0, 1'h1, 1'h1, 1'h0);
      tick(420);
      cmd(1'h1, 1'h0, strap_cfg_pkg::MODE_INIT, 1'h0, 1'h0);
      `CHK("no devmode without flag", 1'h0, devmode_o)
      $display("test straps done");
      conclude();
   end
endmodule : strap_config_and_mode_select_tb
